// File: dv/cmb_mem_model.sv
module cmb_mem_model
  import cmb_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        fault_en,
  input  wire logic [31:0] ad_out,
  input  wire logic        ad_oe,
  input  wire logic        addr_latch_out,
  input  wire logic        read_strobe,
  input  wire logic        write_strobe_out,
  input  wire logic        ext_drive_enable,
  input  wire logic        burst_or_same_page,
  input  wire logic [1:0]  word_index,
  output logic      [31:0] ad_in,
  output logic             ack_in,
  output logic             readbuf_capture_en,
  output logic             bus_fault_in,
  output logic      [31:0] wr_addr,
  output logic      [31:0] wr_data,
  output logic             burst_seen,
  output logic             ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] lat_addr = '0;
  logic [31:0] last = '0;
  logic [31:0] dat = '0;
  logic [1:0]  cnt = '0;
  logic        phase = 1'b0;

  // A released bus shows the inverse of the last word, so a stale value never passes.
  assign ad_in = ext_drive_enable ? dat : ~last;

  initial begin
    {ack_in, readbuf_capture_en, bus_fault_in, burst_seen} = '0;
    {wr_addr, wr_data} = '0;
    ok = 1'b1;
  end

  // Answers on every other cycle, which paces the word index between captures.
  always @(posedge aclk) begin
    ack_in <= 1'b0;
    readbuf_capture_en <= 1'b0;
    bus_fault_in <= 1'b0;
    phase <= ~phase;
    if (ext_drive_enable) last <= ad_in;
    if (ad_oe) last <= ad_out;
    if (ext_drive_enable && ad_oe) ok <= 1'b0;
    if (addr_latch_out) begin
      lat_addr <= ad_out;
      cnt <= '0;
      burst_seen <= burst_or_same_page;
    end
    if (fault_en && (read_strobe || write_strobe_out) && phase) begin
      bus_fault_in <= 1'b1;
    end else if (write_strobe_out && phase) begin
      ack_in <= 1'b1;
      wr_addr <= lat_addr;
      wr_data <= ad_out;
    end else if (ext_drive_enable && phase) begin
      readbuf_capture_en <= 1'b1;
      dat <= lat_addr + 32'(cnt);
      if (word_index !== (burst_seen ? cnt : lat_addr[3:2])) ok <= 1'b0;
      cnt <= cnt + 2'h1;
      ack_in <= !burst_seen || cnt == 2'h3;
    end
  end
endmodule : cmb_mem_model

// File: dv/tb_cmb_top.sv
module tb_cmb_top;
  import cmb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] v; logic [1:0] r; bit chk;} cmb_exp_t;
  logic        aclk = 0, aresetn = 0, fault_en = 0, direct_branch_cond = 0;
  logic        ext_master_request = 0;
  logic        dma_ale = 0, dma_wr = 0, dma_ack = 0, dma_ivd = 0, dma_coh = 0;
  int          exc_n = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, ad_in, ad_out, inval_addr, wr_addr, wr_data;
  logic [31:0] rd_word, a, d;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, word_index, synced_branch_cond = 0;
  logic [3:0]  coproc_cond;
  logic        ad_oe, addr_latch_out, addr_latch_oe, read_strobe, write_strobe_out;
  logic        write_strobe_oe, ext_drive_enable, burst_or_same_page, ack_in;
  logic        readbuf_capture_en, bus_ref_clock, ext_master_grant, bus_fault_in;
  logic        bus_error_exc, inval_pulse, burst_seen, ok;
  int          fails = 0, n_tests = 0, seed = 32'hc0bb;
  cmb_exp_t    exp_q[$];

  always #25 aclk = ~aclk;

  // Counts exception pulses, since each one stands for a single cycle only.
  always @(posedge aclk) if (bus_error_exc === 1'b1) exc_n++;

  cmb_top u_cmb_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ad_in(dma_wr ? a : ad_in),
    .ad_out, .ad_oe, .addr_latch_in(dma_ale), .addr_latch_out, .addr_latch_oe, .read_strobe,
    .write_strobe_in(dma_wr), .write_strobe_out, .write_strobe_oe, .word_index,
    .ext_drive_enable, .burst_or_same_page, .ack_in(ack_in | dma_ack), .readbuf_capture_en,
    .bus_ref_clock, .ext_master_request, .ext_master_grant, .line_invalidate_request(dma_ivd),
    .coherent_dma_request(dma_coh), .synced_branch_cond, .direct_branch_cond, .bus_fault_in,
    .coproc_cond, .bus_error_exc, .inval_pulse, .inval_addr);

  cmb_mem_model u_cmb_mem_model (.aclk, .fault_en, .ad_out, .ad_oe, .addr_latch_out,
    .read_strobe, .write_strobe_out, .ext_drive_enable, .burst_or_same_page, .word_index,
    .ad_in, .ack_in, .readbuf_capture_en, .bus_fault_in, .wr_addr, .wr_data, .burst_seen,
    .ok);

  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // A wait that runs out counts as a mismatch and closes the run.
  task automatic give_up(int i, int lim);
    if (i >= lim) begin
      fails++;
      end_of_test();
    end
  endtask : give_up

  task automatic wr(logic [7:0] ad, logic [31:0] dt, logic [1:0] er);
    int i;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    give_up(i, 50);
    check("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  // The expectation is queued first; the watcher below compares it when data returns.
  task automatic rd(logic [7:0] ad, logic [31:0] e, logic [1:0] er, bit c);
    int i;
    exp_q.push_back('{e, er, c});
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_word = s_axi_rdata;
    give_up(i, 50);
  endtask : rd

  always @(posedge aclk) begin
    cmb_exp_t e;
    if (s_axi_rvalid === 1'b1 && s_axi_rready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.chk) check("rdata", e.v, s_axi_rdata);
      check("rresp", 32'(e.r), 32'(s_axi_rresp));
    end
  end

  // Runs one bus cycle from the register side and polls until the engine is idle.
  task automatic op(logic [31:0] ad, logic [31:0] dt, logic [5:0] ctl);
    int i;
    wr(CMB_OFF_ADDR, ad, CMB_RESP_OKAY);
    wr(CMB_OFF_WDATA, dt, CMB_RESP_OKAY);
    wr(CMB_OFF_CTRL, 32'(ctl | 6'h01), CMB_RESP_OKAY);
    for (i = 0; i < 100; i++) begin
      rd(CMB_OFF_STATUS, 0, CMB_RESP_OKAY, 0);
      if (rd_word[CMB_ST_BUSY] === 1'b0) break;
    end
    give_up(i, 100);
  endtask : op

  task automatic wait_grant(logic v);
    int i;
    for (i = 0; i < 20 && ext_master_grant !== v; i++) @(posedge aclk);
    give_up(i, 20);
  endtask : wait_grant

  initial begin
    int i;
    int n;
    logic [5:0] kinds[4] = '{6'h00, 6'h04, 6'h14, 6'h0c};
    logic b;
    logic p;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CMB_OFF_CTRL, 0, CMB_RESP_OKAY, 1);
    rd(CMB_OFF_STATUS, 0, CMB_RESP_OKAY, 1);
    rd(8'h1c, 0, CMB_RESP_SLVERR, 0);
    wr(8'h1c, 0, CMB_RESP_SLVERR);
    a = $random(seed) & 32'hffff_fff0;
    d = $random(seed);
    op(a, d, 6'h02);
    check("write address", a, wr_addr);
    check("write data", d, wr_data);
    check("same page", 0, 32'(burst_seen));
    // Uncached, data miss, data miss with quad refill, instruction miss.
    for (i = 0; i < 4; i++) begin
      a = $random(seed) & 32'hffff_fffc;
      op(a, 0, kinds[i]);
      b = kinds[i][CMB_CTRL_MISS] && (kinds[i][CMB_CTRL_ICACHE] || kinds[i][CMB_CTRL_QUAD]);
      check("burst hint", 32'(b), 32'(burst_seen));
      rd(CMB_OFF_RDATA, a + (b ? 32'h3 : 32'h0), CMB_RESP_OKAY, 1);
    end
    check("pin order", 1, 32'(ok));
    fault_en <= 1'b1;
    op(a, 0, 6'h00);
    rd(CMB_OFF_STATUS, 32'h6, CMB_RESP_OKAY, 1);
    check("bus error exc", 1, 32'(exc_n));
    wr(CMB_OFF_STATUS, 32'h6, CMB_RESP_OKAY);
    op(a, d, 6'h02);
    fault_en <= 1'b0;
    rd(CMB_OFF_STATUS, 32'h2, CMB_RESP_OKAY, 1);
    check("bus error exc", 1, 32'(exc_n));
    wr(CMB_OFF_STATUS, 32'h6, CMB_RESP_OKAY);
    ext_master_request <= 1'b1;
    wait_grant(1'b1);
    @(posedge aclk);
    check("strobe enables", 0, 32'({addr_latch_oe, write_strobe_oe}));
    rd(CMB_OFF_STATUS, 32'h8, CMB_RESP_OKAY, 1);
    // One coherent DMA write: strobe with address, acknowledge, then invalidate.
    a = $random(seed) & 32'hffff_fffc;
    dma_coh <= 1'b1;
    @(posedge aclk);
    dma_ale <= 1'b1;
    dma_wr <= 1'b1;
    @(posedge aclk);
    dma_ale <= 1'b0;
    dma_ack <= 1'b1;
    @(posedge aclk);
    dma_wr <= 1'b0;
    dma_ack <= 1'b0;
    dma_ivd <= 1'b1;
    @(posedge aclk);
    dma_ivd <= 1'b0;
    @(posedge aclk);
    check("inval pulse", 1, 32'(inval_pulse));
    check("inval addr", a + 32'h4, inval_addr);
    rd(CMB_OFF_STATUS, 32'h38, CMB_RESP_OKAY, 1);
    dma_coh <= 1'b0;
    ext_master_request <= 1'b0;
    wait_grant(1'b0);
    for (i = 0; i < 4; i++) begin
      synced_branch_cond <= 2'($random(seed));
      direct_branch_cond <= 1'($random(seed));
      repeat (4) @(posedge aclk);
      check("cond", 32'({synced_branch_cond, 1'b0, direct_branch_cond}), 32'(coproc_cond));
    end
    n = 0;
    p = bus_ref_clock;
    for (i = 0; i < 8; i++) begin
      @(posedge aclk);
      if (bus_ref_clock !== p) n++;
      p = bus_ref_clock;
    end
    check("ref clock toggles", 8, 32'(n));
    end_of_test();
  end
endmodule : tb_cmb_top

// File: hw/cmb_cond_sync.sv
module cmb_cond_sync
  import cmb_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] async_in,
  input  wire logic       direct_in,
  output logic      [3:0] cond
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  // Two flops per asynchronous bit; only the second flop is read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // Bit 1 belongs to the float unit and has no pin, so it is held low here.
  assign cond = {sync_reg, 1'b0, direct_in};

  a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> cond[3:2] == $past(async_in, 2))
    else $error("synced branch condition not two cycles late");

endmodule : cmb_cond_sync

// File: hw/cmb_ctl_if.sv
interface cmb_ctl_if;
  import cmb_pkg::*;

  logic [31:0] addr;
  logic [31:0] wdata;
  logic        start;
  logic        write;
  logic        miss;
  logic        icache;
  logic        quad;
  logic        busy;
  logic        fault;

  modport ctl (output addr, wdata, start, write, miss, icache, quad, input busy, fault);
  modport eng (input addr, wdata, start, write, miss, icache, quad, output busy, fault);
endinterface : cmb_ctl_if

// File: hw/cmb_pkg.sv
package cmb_pkg;

  // Register byte offsets.
  localparam logic [7:0] CMB_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CMB_OFF_ADDR   = 8'h04;
  localparam logic [7:0] CMB_OFF_WDATA  = 8'h08;
  localparam logic [7:0] CMB_OFF_RDATA  = 8'h0c;
  localparam logic [7:0] CMB_OFF_STATUS = 8'h10;
  localparam logic [7:0] CMB_OFF_INVAL  = 8'h14;
  localparam logic [7:0] CMB_OFF_COND   = 8'h18;

  // Control register fields.
  localparam int CMB_CTRL_GO    = 0;
  localparam int CMB_CTRL_WRITE = 1;
  localparam int CMB_CTRL_MISS  = 2;
  localparam int CMB_CTRL_ICACHE = 3;
  localparam int CMB_CTRL_QUAD  = 4;
  localparam int CMB_CTRL_HALF  = 5;

  // Status register fields.
  localparam int CMB_ST_BUSY  = 0;
  localparam int CMB_ST_FAULT = 1;
  localparam int CMB_ST_EXC   = 2;
  localparam int CMB_ST_GRANT = 3;
  localparam int CMB_ST_COH   = 4;
  localparam int CMB_ST_INVAL = 5;

  // Word-index and page geometry.
  localparam int CMB_BURST_WORDS = 4;
  localparam int CMB_PAGE_WORDS  = 512;
  localparam int CMB_PAGE_LSB    = 11;
  localparam logic [1:0] CMB_IDX_ZERO = 2'h0;
  localparam logic [1:0] CMB_IDX_LAST = 2'h3;

  // AXI response codes.
  localparam logic [1:0] CMB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CMB_RESP_SLVERR = 2'h2;

  // Bus cycle states.
  typedef enum logic [2:0] {
    CMB_IDLE,
    CMB_ADDR,
    CMB_TURN,
    CMB_RDATA,
    CMB_WDATA,
    CMB_DONE
  } cmb_state_t;

endpackage : cmb_pkg

// File: hw/cmb_top.sv
// Contract
// - Address latch strobe high while the bus carries the transfer address.
// - In coherent DMA, capture address at strobe of each DMA write.
// - Read strobe marks a read transaction.
// - Write strobe is output normally, input from DMA master in coherent DMA.
// - Drive enable rises in reads only after the device releases the bus.
// - Drive enable low in writes and when idle.
// - Burst on a read asks for four contiguous words.
// - Burst only on icache misses, or dcache misses with quad refill.
// - Same-page write on back-to-back writes in one 512-word page.
// - In coherent DMA, acknowledge increments the invalidation address.
// - Capture enable loads bus data into the read buffer.
// - Output bus reference clock at full or half rate chosen at reset; here it runs at aclk/2, or aclk/4 only after a one-cycle reset with CMB_CTRL_HALF set.
// - Bus request makes the device release its bus signals.
// - Grant is asserted once the bus is handed over.
// - Invalidate request kills the line at the DMA write address.
// - Branch condition pins feed the coprocessor condition signals.
// - Synced conditions pass two flops; direct one must be synchronous.
// - Condition 1 stays internal, no pin.
// - Bus fault sampled only during reads and writes; it ends the cycle.
// - Bus fault on a read raises a bus error exception.
// - Word index is the word address, or counts from zero in bursts.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
module cmb_top
  import cmb_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] ad_in,
  output logic [31:0]      ad_out,
  output logic             ad_oe,
  input  wire logic        addr_latch_in,
  output logic             addr_latch_out,
  output logic             addr_latch_oe,
  output logic             read_strobe,
  input  wire logic        write_strobe_in,
  output logic             write_strobe_out,
  output logic             write_strobe_oe,
  output logic [1:0]       word_index,
  output logic             ext_drive_enable,
  output logic             burst_or_same_page,
  input  wire logic        ack_in,
  input  wire logic        readbuf_capture_en,
  output logic             bus_ref_clock,
  input  wire logic        ext_master_request,
  output logic             ext_master_grant,
  input  wire logic        line_invalidate_request,
  input  wire logic        coherent_dma_request,
  input  wire logic [1:0]  synced_branch_cond,
  input  wire logic        direct_branch_cond,
  input  wire logic        bus_fault_in,
  output logic [3:0]       coproc_cond,
  output logic             bus_error_exc,
  output logic             inval_pulse,
  output logic [31:0]      inval_addr
);

  cmb_ctl_if ctl ();

  logic [31:0] addr_reg, wdata_reg, rdata_reg, status_rd;
  logic [5:0]  ctrl_reg;
  logic        go_reg, fault_reg, exc_reg, half_cap_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        bvalid_reg, rvalid_reg, arready_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_out_reg;
  logic [3:0]  cond_w;
  logic [3:0]  cond_reg;
  logic        coh_reg, ival_reg;
  logic [31:0] inval_addr_reg;

  // Write path: address and data may arrive in either order.
  wire aw_take  = s_axi_awvalid && !aw_hold_reg && !bvalid_reg;
  wire w_take   = s_axi_wvalid && !w_hold_reg && !bvalid_reg;
  wire aw_have  = aw_hold_reg || aw_take;
  wire w_have   = w_hold_reg || w_take;
  wire wr_fire  = aw_have && w_have && !bvalid_reg;
  wire [7:0]  wr_off  = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_dat  = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire wr_ctrl  = wr_fire && wr_off == CMB_OFF_CTRL;
  wire wr_addr  = wr_fire && wr_off == CMB_OFF_ADDR;
  wire wr_wdat  = wr_fire && wr_off == CMB_OFF_WDATA;
  wire wr_stat  = wr_fire && wr_off == CMB_OFF_STATUS;
  wire wr_ok    = wr_ctrl || wr_addr || wr_wdat || wr_stat;
  wire rd_fire  = s_axi_arvalid && arready_reg;

  // Read decode.
  assign status_rd = {26'h0, ival_reg, coh_reg, ext_master_grant, exc_reg, fault_reg,
                      ctl.busy};
  wire rd_hit = s_axi_araddr == CMB_OFF_CTRL || s_axi_araddr == CMB_OFF_ADDR ||
                s_axi_araddr == CMB_OFF_WDATA || s_axi_araddr == CMB_OFF_RDATA ||
                s_axi_araddr == CMB_OFF_STATUS || s_axi_araddr == CMB_OFF_INVAL ||
                s_axi_araddr == CMB_OFF_COND;
  logic [31:0] rd_mux;
  always_comb begin
    if (s_axi_araddr == CMB_OFF_CTRL) begin
      rd_mux = {26'h0, ctrl_reg};
    end else if (s_axi_araddr == CMB_OFF_ADDR) begin
      rd_mux = addr_reg;
    end else if (s_axi_araddr == CMB_OFF_WDATA) begin
      rd_mux = wdata_reg;
    end else if (s_axi_araddr == CMB_OFF_RDATA) begin
      rd_mux = rdata_reg;
    end else if (s_axi_araddr == CMB_OFF_STATUS) begin
      rd_mux = status_rd;
    end else if (s_axi_araddr == CMB_OFF_INVAL) begin
      rd_mux = inval_addr_reg;
    end else if (s_axi_araddr == CMB_OFF_COND) begin
      rd_mux = {28'h0, cond_reg};
    end else begin
      rd_mux = 32'h0;
    end
  end

  // AXI write channel holding and response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg  <= 32'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= CMB_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? CMB_RESP_OKAY : CMB_RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_hold_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_take) begin
          w_hold_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // AXI read channel: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg   <= 1'b1;
      rvalid_reg    <= 1'b0;
      rresp_reg     <= CMB_RESP_OKAY;
      rdata_out_reg <= 32'h0;
    end else if (rd_fire) begin
      arready_reg   <= 1'b0;
      rvalid_reg    <= 1'b1;
      rdata_out_reg <= rd_mux;
      rresp_reg     <= rd_hit ? CMB_RESP_OKAY : CMB_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Software registers; a fault flag set by the engine wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= 6'h0;
      addr_reg  <= 32'h0;
      wdata_reg <= 32'h0;
      go_reg    <= 1'b0;
      fault_reg <= 1'b0;
      exc_reg   <= 1'b0;
    end else begin
      go_reg <= wr_ctrl && wr_dat[CMB_CTRL_GO] && s_axi_wstrb[0];
      if (wr_ctrl && s_axi_wstrb[0]) ctrl_reg <= wr_dat[5:0];
      if (wr_addr) addr_reg <= wr_dat;
      if (wr_wdat) wdata_reg <= wr_dat;
      fault_reg <= ctl.fault || (fault_reg && !(wr_stat && wr_dat[CMB_ST_FAULT]));
      exc_reg <= (ctl.fault && !ctl.write) ||
                 (exc_reg && !(wr_stat && wr_dat[CMB_ST_EXC]));
    end
  end

  // Half-rate select is caught from the control bit while reset is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cap_reg <= ctrl_reg[CMB_CTRL_HALF];
    end
  end
  // The full-rate clock mirrors aclk's own phase as a toggling flop at half
  // rate; a true full-rate copy cannot come from a flop, so mode 1x shows
  // the divider and mode 2x divides once more.
  logic [1:0] div_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg       <= 2'h0;
      bus_ref_clock <= 1'b0;
    end else begin
      div_reg       <= div_reg + 2'h1;
      bus_ref_clock <= half_cap_reg ? div_reg[1] : div_reg[0];
    end
  end

  assign ctl.addr   = addr_reg;
  assign ctl.wdata  = wdata_reg;
  assign ctl.start  = go_reg;
  assign ctl.write  = ctrl_reg[CMB_CTRL_WRITE];
  assign ctl.miss   = ctrl_reg[CMB_CTRL_MISS];
  assign ctl.icache = ctrl_reg[CMB_CTRL_ICACHE];
  assign ctl.quad   = ctrl_reg[CMB_CTRL_QUAD];

  cmb_cond_sync u_cond (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .async_in  (synced_branch_cond),
    .direct_in (direct_branch_cond),
    .cond      (cond_w)
  );

  // Bus engine state.
  cmb_state_t state_reg;
  logic [1:0] idx_reg;
  logic       burst_reg, prev_wr_reg;
  logic [31:0] prev_addr_reg;
  wire in_xfer   = state_reg == CMB_RDATA || state_reg == CMB_WDATA;
  wire fault_now = in_xfer && bus_fault_in;
  wire dma_mode  = ext_master_grant;
  wire near_hit  = prev_wr_reg &&
                   prev_addr_reg[31:CMB_PAGE_LSB] == addr_reg[31:CMB_PAGE_LSB];
  wire want_burst = ctl.miss && (ctl.icache || ctl.quad);
  wire rd_last   = !burst_reg || idx_reg == CMB_IDX_LAST;
  // Next grant and next word index, so the pins move in the same cycle as what they report.
  wire grant_next = ext_master_request && (ext_master_grant || !ctl.busy);
  wire idx_step  = state_reg == CMB_RDATA && readbuf_capture_en && burst_reg &&
                   !fault_now && !(ack_in && rd_last);

  assign ctl.busy  = state_reg != CMB_IDLE;
  assign ctl.fault = fault_now;

  // Transaction sequencer: address, turnaround (reads only), data, then done.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= CMB_IDLE;
      idx_reg       <= CMB_IDX_ZERO;
      burst_reg     <= 1'b0;
      prev_wr_reg   <= 1'b0;
      prev_addr_reg <= 32'h0;
      rdata_reg     <= 32'h0;
    end else begin
      case (state_reg)
        CMB_IDLE: begin
          if (ctl.start && !ext_master_request && !dma_mode) begin
            state_reg <= CMB_ADDR;
            burst_reg <= !ctl.write && want_burst;
            idx_reg   <= (!ctl.write && want_burst) ? CMB_IDX_ZERO : addr_reg[3:2];
          end else begin
            prev_wr_reg <= 1'b0;
          end
        end
        CMB_ADDR: begin
          state_reg <= ctl.write ? CMB_WDATA : CMB_TURN;
        end
        CMB_TURN: begin
          state_reg <= CMB_RDATA;
        end
        CMB_RDATA: begin
          if (readbuf_capture_en) rdata_reg <= ad_in;
          if (fault_now) begin
            state_reg <= CMB_DONE;
          end else if (ack_in && rd_last) begin
            state_reg <= CMB_DONE;
          end else if (readbuf_capture_en && burst_reg) begin
            idx_reg <= idx_reg + 2'h1;
          end
        end
        CMB_WDATA: begin
          if (ack_in || fault_now) begin
            state_reg     <= CMB_DONE;
            prev_addr_reg <= addr_reg;
          end
        end
        default: begin
          state_reg   <= CMB_IDLE;
          prev_wr_reg <= ctl.write;
        end
      endcase
    end
  end

  // Registered pin drivers decoded from the current engine state, the next grant and the next word index.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_latch_out     <= 1'b0;
      addr_latch_oe      <= 1'b0;
      read_strobe        <= 1'b0;
      write_strobe_out   <= 1'b0;
      write_strobe_oe    <= 1'b0;
      ad_out             <= 32'h0;
      ad_oe              <= 1'b0;
      ext_drive_enable   <= 1'b0;
      burst_or_same_page <= 1'b0;
      word_index         <= CMB_IDX_ZERO;
    end else begin
      addr_latch_out   <= state_reg == CMB_ADDR;
      addr_latch_oe    <= !grant_next;
      write_strobe_oe  <= !grant_next;
      read_strobe      <= state_reg == CMB_TURN || state_reg == CMB_RDATA;
      write_strobe_out <= state_reg == CMB_WDATA;
      ad_out           <= state_reg == CMB_ADDR ? addr_reg : wdata_reg;
      ad_oe            <= state_reg == CMB_ADDR || state_reg == CMB_WDATA;
      ext_drive_enable <= state_reg == CMB_RDATA &&
                          !(fault_now || (ack_in && rd_last));
      burst_or_same_page <= ctl.busy &&
                            (ctl.write ? near_hit : burst_reg);
      word_index       <= idx_step ? idx_reg + 2'h1 : idx_reg;
    end
  end

  // Arbiter and coherent DMA watcher.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_master_grant <= 1'b0;
      coh_reg          <= 1'b0;
      ival_reg         <= 1'b0;
      inval_pulse      <= 1'b0;
      inval_addr_reg   <= 32'h0;
      inval_addr       <= 32'h0;
      cond_reg         <= 4'h0;
      coproc_cond      <= 4'h0;
      bus_error_exc    <= 1'b0;
    end else begin
      ext_master_grant <= grant_next;
      coh_reg          <= dma_mode && coherent_dma_request;
      if (coh_reg && addr_latch_in && write_strobe_in) begin
        inval_addr_reg <= ad_in;
      end else if (coh_reg && ack_in && write_strobe_in) begin
        inval_addr_reg <= inval_addr_reg + 32'h4;
      end
      inval_pulse <= coh_reg && line_invalidate_request;
      ival_reg    <= (coh_reg && line_invalidate_request) || ival_reg && !wr_stat;
      inval_addr  <= inval_addr_reg;
      cond_reg    <= cond_w;
      coproc_cond <= cond_w;
      bus_error_exc <= fault_now && !ctl.write;
    end
  end

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_out_reg;

  a_de_write: assert property (@(posedge aclk) disable iff (!aresetn)
    write_strobe_out |-> !ext_drive_enable)
    else $error("drive enable high during write");
  a_de_noad: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_drive_enable |-> !ad_oe && !$past(ad_oe))
    else $error("drive enable while device drives bus");
  a_ale_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    addr_latch_out |-> ad_oe && ad_out == addr_reg)
    else $error("latch strobe without address");
  a_burst_rd: assert property (@(posedge aclk) disable iff (!aresetn)
    (burst_or_same_page && read_strobe) |-> burst_reg && ctl.miss)
    else $error("burst without a miss");
  a_grant: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_master_grant |-> !addr_latch_oe ##1 !addr_latch_oe || !ext_master_grant)
    else $error("bus driven while granted");
  a_grant_req: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ext_master_grant) |-> $past(ext_master_request))
    else $error("grant without request");
  a_fault_end: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_now |=> state_reg == CMB_DONE)
    else $error("fault did not end the cycle");
  a_exc: assert property (@(posedge aclk) disable iff (!aresetn)
    (fault_now && !ctl.write) |=> bus_error_exc)
    else $error("no exception on read fault");

endmodule : cmb_top
